//--- src/adc_seq_consts.svh
// Purpose: named constants for the channel sequencer and conversion control
// Assumes: 25 MHz system clock
// Notes: register offsets are byte addresses on the bus
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// system clock period and conversion time
`define SYS_CLK_NS 40
`define CONV_TIME_NS 660
// least time, so round up to whole cycles
`define CONV_CYCLES ((`CONV_TIME_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

// result and readout widths
`define CODE_W 14
`define SHIFT_W 20

// results still flagged invalid after a start event
`define DISCARD_NORM 2'h2
`define DISCARD_LP 2'h1
`define DISCARD_WAKE 2'h1

// register byte offsets
`define REG_CTRL_OFF 8'h00
`define REG_STAT_OFF 8'h04
`define REG_RESULT_OFF 8'h08
`define CTRL_RESET 32'h0000_0001
`define CTRL_EXTRA_BIT 0

`endif

//--- src/adc_seq_pkg.sv
// Purpose: shared types for the channel sequencer block
// Assumes: constants come from adc_seq_consts.svh
// Notes: state encodings are gray along idle, convert, read
package adc_seq_pkg;

  // conversion state, one bit changes per step except read back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_READ = 2'h3
  } conv_state_e;

  // gain selection as applied to the amplifier
  typedef struct packed {
    logic bypass;
    logic [2:0] code;
  } gain_cfg_s;

  // synchronised pin levels
  typedef struct packed {
    logic cs_n;
    logic pwr_n;
    logic lp_sel;
    logic gate;
    logic [2:0] chan;
    logic [2:0] gain;
    logic gain_hiz;
    logic bip;
    logic sck;
  } pin_bundle_s;

  // whole state of the main control module
  typedef struct packed {
    logic cs_d;
    logic gate_d;
    logic pwr_d;
    logic sck_d;
    conv_state_e st;
    logic [7:0] cnt;
    logic seq_run;
    logic seq_reload;
    logic seq_exit;
    logic [2:0] seq_ptr;
    logic [2:0] chan_q;
    logic [2:0] chan_act;
    gain_cfg_s gain_q;
    gain_cfg_s gain_act;
    logic [2:0] conv_chan;
    gain_cfg_s conv_gain;
    logic [1:0] discard;
    logic [13:0] result;
    logic res_valid;
    logic [19:0] shreg;
  } seq_state_s;

endpackage : adc_seq_pkg

//--- src/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 14
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // both stages kept in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_s;

  sync_state_s q; // registered stages
  sync_state_s n; // next stages

  // first stage feeds the second and nothing else
  always_comb begin
    n = q;
    n.s1 = async_in;
    n.s2 = q.s1;
  end

  // frozen while the clock enable is low
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign sync_out = q.s2;
endmodule : pin_sync

//--- src/ahb_regs.sv
// Purpose: AHB-Lite slave holding control and exposing status and result
// Assumes: single word transfers only, zero wait states
// Notes: unmapped reads return zero, writes there are dropped, always OKAY
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module ahb_regs (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] status_in,
  input wire logic [31:0] result_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic extra_bits_out
);
  import adc_seq_pkg::*;

  // bus slave state
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } bus_state_s;

  bus_state_s q;
  bus_state_s n;
  logic take; // address phase accepted

  // read decode, shared by the read path
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] c,
                                         input logic [31:0] s, input logic [31:0] r);
    case (a)
      `REG_CTRL_OFF: rd_mux = c;
      `REG_STAT_OFF: rd_mux = s;
      `REG_RESULT_OFF: rd_mux = r;
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // capture address phase, apply write in data phase
  always_comb begin
    n = q;
    take = hsel_in && htrans_in[1] && hready_in;
    if (q.wr_pend && q.wr_addr == `REG_CTRL_OFF) begin
      n.ctrl = hwdata_in;
    end
    n.wr_pend = take && hwrite_in;
    n.wr_addr = haddr_in[7:0];
    // read data is latched so it stands through the data phase
    if (take && !hwrite_in) begin
      n.rdata = rd_mux(haddr_in[7:0], q.ctrl, status_in, result_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '{wr_pend: 1'b0, wr_addr: 8'h0, ctrl: `CTRL_RESET, rdata: 32'h0};
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign hrdata_out = q.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign extra_bits_out = q.ctrl[`CTRL_EXTRA_BIT];
endmodule : ahb_regs

//--- src/adc_seq_ctrl.sv
// Purpose: conversion start, channel sequencer and gain timing for an 8-input converter
// Assumes: all pins arrive asynchronously and pass two flip-flops first
// Notes: the converter core supplies an offset-binary code on core_code_in
// Functional notes
// R01: gate high steps channels 0..7, then wraps
// R02: normal mode flags first two results invalid
// R03: channel 0 sampled at second falling start
// R04: each start rise advances channel by one
// R05: normal mode gain applies next cycle
// R06: host drops first low-power sequencer result
// R07: low-power gain applies to same sample
// R08: channel pins ignored while sequencer runs
// R09: one extra sequenced sample after gate drops
// R10: readout channel bits show sequencer choice
// R11: host lengthens period for extra bits
// R12: falling start begins internally timed conversion
// R13: data driver on only when start low
// R14: host keeps start low when inactive
// R15: power-down aborts conversion, output high impedance
// R16: normal wake gives one invalid sample
// R17: low-power wake sample valid immediately
// R18: host holds gate for whole sequence
// R19: gain may change during sequencing
// R20: common input floating selects bipolar coding
// R21: bipolar two's complement, unipolar unsigned
// R22: channel pins are straight binary
// R23: floating gain msb bypasses, else table
// R24: pointer reloads to zero on gate rise
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_seq_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic convert_start_n_in,
  input wire logic power_down_n_in,
  input wire logic low_power_select_in,
  input wire logic sequencer_gate_in,
  input wire logic [2:0] chan_sel_bits_in,
  input wire logic [2:0] gain_sel_bits_in,
  input wire logic gain_msb_bypass_pin_in,
  input wire logic common_input_in,
  input wire logic sck_in,
  input wire logic [13:0] core_code_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic busy_out,
  output logic result_valid_out,
  output logic [2:0] active_chan_out,
  output adc_seq_pkg::gain_cfg_s active_gain_out
);
  import adc_seq_pkg::*;

  pin_bundle_s p; // synchronised pins
  seq_state_s q; // registered state
  seq_state_s n; // next state
  logic extra_bits; // readout carries channel and gain bits
  logic cs_rise; // start pin went high
  logic cs_fall; // start pin went low
  logic gate_rise; // sequencer gate went high
  logic pwr_rise; // leaving power-down
  logic sck_fall; // serial clock falling edge
  gain_cfg_s pin_gain; // gain as read from the pins now
  logic [31:0] status_word; // packed status for the bus
  logic [31:0] result_word; // last result for the bus

  // floating msb bypasses the amplifier, low bits then ignored
  function automatic gain_cfg_s gain_decode(input logic hiz, input logic [2:0] g);
    gain_decode.bypass = hiz; // R23
    gain_decode.code = hiz ? 3'h0 : g; // R23
  endfunction : gain_decode

  // amplifier factor reported in status; zero means bypassed
  function automatic logic [4:0] gain_factor(input gain_cfg_s g);
    if (g.bypass) begin
      gain_factor = 5'h00;
    end else begin
      case (g.code)
        3'h0: gain_factor = 5'h01;
        3'h1: gain_factor = 5'h02;
        3'h2: gain_factor = 5'h03;
        3'h3: gain_factor = 5'h04;
        3'h4: gain_factor = 5'h06;
        3'h5: gain_factor = 5'h08;
        3'h6: gain_factor = 5'h0c;
        default: gain_factor = 5'h10;
      endcase
    end
  endfunction : gain_factor

  // every pin passes two flip-flops before any decision
  pin_sync #(
    .W($bits(pin_bundle_s))
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .async_in({convert_start_n_in, power_down_n_in, low_power_select_in,
               sequencer_gate_in, chan_sel_bits_in, gain_sel_bits_in,
               gain_msb_bypass_pin_in, common_input_in, sck_in}),
    .sync_out(p)
  );

  // status layout: bipolar, sequencing, busy, valid, gain factor, channel
  assign status_word = {17'h0, p.bip, q.seq_run, busy_out, q.res_valid,
                        3'h0, gain_factor(q.gain_act), q.chan_act};
  assign result_word = {18'h0, q.result};

  ahb_regs u_regs (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .status_in(status_word),
    .result_in(result_word),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .extra_bits_out(extra_bits)
  );

  // edge detection on the second synchroniser stage only
  assign cs_rise = p.cs_n && !q.cs_d;
  assign cs_fall = !p.cs_n && q.cs_d;
  assign gate_rise = p.gate && !q.gate_d;
  assign pwr_rise = p.pwr_n && !q.pwr_d;
  assign sck_fall = !p.sck && q.sck_d;
  assign pin_gain = gain_decode(p.gain_hiz, p.gain);

  // sequencer, gain timing, conversion and readout in one next-state block
  always_comb begin
    n = q;
    n.cs_d = p.cs_n;
    n.gate_d = p.gate;
    n.pwr_d = p.pwr_n;
    n.sck_d = p.sck;
    // gate rise arms a reload of the pointer
    if (gate_rise) begin
      n.seq_reload = 1'b1; // R24
    end
    // start rise: latch pins and step the sequencer
    if (cs_rise && p.pwr_n) begin
      n.gain_q = pin_gain;
      n.chan_q = p.chan;
      // low power applies now, normal mode one sample later
      n.gain_act = p.lp_sel ? pin_gain : q.gain_q; // R05 R07 R17 R19
      if (p.gate && (!q.seq_run || q.seq_reload || gate_rise)) begin
        // first rise with gate high loads channel 0 for the next fall
        n.seq_run = 1'b1; // R03 R24
        n.seq_ptr = 3'h0; // R03 R24
        n.seq_reload = 1'b0;
        n.seq_exit = 1'b0;
        if (p.lp_sel) begin
          n.discard = `DISCARD_LP; // R06
        end
      end else if (p.gate) begin
        // three-bit pointer wraps from 7 to 0 by itself
        n.seq_ptr = q.seq_ptr + 3'h1; // R01 R04
      end else if (q.seq_run && !q.seq_exit) begin
        // gate gone: one more channel from the sequence
        n.seq_ptr = q.seq_ptr + 3'h1; // R09
        n.seq_exit = 1'b1; // R09
      end else if (q.seq_run) begin
        n.seq_run = 1'b0; // R09
        n.seq_exit = 1'b0;
      end
      // pins steer only when the sequencer is idle
      if (n.seq_run) begin
        n.chan_act = n.seq_ptr; // R08
      end else begin
        n.chan_act = p.lp_sel ? p.chan : q.chan_q; // R08 R22
      end
      if (q.st == ST_READ) begin
        n.st = ST_IDLE;
      end
    end
    case (q.st)
      ST_IDLE, ST_READ: begin
        // falling start launches a conversion timed by our own counter
        if (cs_fall && p.pwr_n) begin
          n.st = ST_CONV; // R12
          n.cnt = 8'(`CONV_CYCLES); // R12
          n.conv_chan = q.chan_act;
          n.conv_gain = q.gain_act;
        end else if (q.st == ST_READ && sck_fall && !p.cs_n) begin
          n.shreg = {q.shreg[`SHIFT_W-2:0], 1'b0};
        end
      end
      ST_CONV: begin
        n.cnt = q.cnt - 8'h1;
        if (q.cnt == 8'h1) begin
          n.st = ST_READ;
          // bipolar flips the offset msb into two's complement
          n.result = {core_code_in[`CODE_W-1] ^ p.bip, core_code_in[`CODE_W-2:0]}; // R20 R21
          n.res_valid = (q.discard == 2'h0); // R02 R16
          n.discard = (q.discard == 2'h0) ? 2'h0 : q.discard - 2'h1;
          // extra bits report what was converted, sequencer or pins
          n.shreg = {n.result,
                     extra_bits ? q.conv_chan : 3'h0, // R10
                     extra_bits ? q.conv_gain.code : 3'h0};
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // arming comes after the end-of-conversion count-down, so an event in the
    // same cycle as a finished result is not lost: the set wins
    if (gate_rise && !p.lp_sel) begin
      n.discard = `DISCARD_NORM; // R02
    end
    // normal wake: the first sample after power-down is not trusted
    if (pwr_rise && !p.lp_sel && q.discard == 2'h0) begin
      n.discard = `DISCARD_WAKE; // R16
    end
    // power-down wins over the state and counter and drops a running conversion
    if (!p.pwr_n) begin
      n.st = ST_IDLE; // R15
      n.cnt = 8'h0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  // driver follows start and power-down levels directly
  assign sdo_oe_out = !p.cs_n && p.pwr_n; // R13 R15
  assign sdo_out = q.shreg[`SHIFT_W-1];
  assign busy_out = (q.st == ST_CONV);
  assign result_valid_out = q.res_valid;
  assign active_chan_out = q.chan_act;
  assign active_gain_out = q.gain_act;

  chk_sdo_hiz_high: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R13
    p.cs_n |-> !sdo_oe_out) else $error("data driver on while start is high");

  chk_pwr_abort: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R15
    (ce_in && !p.pwr_n) |-> (!sdo_oe_out ##1 !busy_out))
    else $error("conversion not aborted in power-down");

  chk_seq_wrap: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R01
    (ce_in && cs_rise && p.pwr_n && p.gate && q.seq_run && !q.seq_reload && !gate_rise
     && q.seq_ptr == 3'h7) |=> (q.seq_ptr == 3'h0 && q.chan_act == 3'h0))
    else $error("sequencer did not wrap to channel 0");

  chk_seq_step: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R04
    (ce_in && cs_rise && p.pwr_n && p.gate && q.seq_run && !q.seq_reload && !gate_rise)
    |=> q.chan_act == $past(q.seq_ptr) + 3'h1)
    else $error("sequencer did not advance by one");

  chk_gate_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R24
    (ce_in && cs_rise && p.pwr_n && p.gate && (q.seq_reload || !q.seq_run))
    |=> (q.seq_run && q.chan_act == 3'h0)) else $error("pointer not reloaded to 0");

  chk_lp_gain: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R07
    (ce_in && cs_rise && p.pwr_n && p.lp_sel) |=> q.gain_act == $past(pin_gain))
    else $error("low-power gain not applied to same sample");

  chk_norm_gain: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R05
    (ce_in && cs_rise && p.pwr_n && !p.lp_sel) |=> q.gain_act == $past(q.gain_q))
    else $error("normal gain not delayed by one sample");

  chk_pins_ignored: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R08
    (ce_in && cs_rise && p.pwr_n && p.gate) |=> q.chan_act == q.seq_ptr)
    else $error("channel pins used while sequencing");

  chk_conv_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R12
    (ce_in && cs_fall && p.pwr_n && q.st != ST_CONV) |=> (busy_out && q.cnt == 8'(`CONV_CYCLES)))
    else $error("falling start did not launch conversion");

  chk_bip_code: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R21
    (ce_in && p.pwr_n && busy_out && q.cnt == 8'h1) |=>
    q.result[13] == ($past(core_code_in[13]) ^ $past(p.bip)))
    else $error("output coding does not follow common input");

  chk_exit_extra: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R09
    (ce_in && cs_rise && p.pwr_n && !p.gate && q.seq_run && !q.seq_exit)
    |=> (q.seq_run && q.chan_act == $past(q.seq_ptr) + 3'h1))
    else $error("no extra sequenced sample after gate drop");
endmodule : adc_seq_ctrl

//--- testbench/host_link_model.sv
// Purpose: host side model driving start, serial clock and gate, and gathering readout words
// Assumes: start idles low between frames, serial clock stands still outside frames
// Notes: the gate request is applied one cycle after start rises, while start is high
`timescale 1ns/1ps
module host_link_model (
  input wire logic sys_clk_in,
  input wire logic go_in,
  input wire logic gate_req_in,
  input wire logic busy_in,
  input wire logic sdo_in,
  output logic convert_start_n_out,
  output logic sck_out,
  output logic gate_out,
  output logic [19:0] word_out,
  output logic done_out
);
  int k; // wait and bit counter
  logic [19:0] w; // bits gathered so far
  // idle levels: start low while inactive, serial clock still
  initial begin
    convert_start_n_out = 1'b0;
    sck_out = 1'b0;
    gate_out = 1'b0;
    word_out = 20'h0;
    done_out = 1'b0;
  end
  // one frame per go pulse: rise latches pins, fall converts, then 20 bits shift out
  always @(posedge sys_clk_in) begin
    if (go_in === 1'b1) begin
      convert_start_n_out <= 1'b1;
      @(posedge sys_clk_in);
      gate_out <= gate_req_in;
      repeat (3) @(posedge sys_clk_in);
      convert_start_n_out <= 1'b0;
      k = 0;
      // bounded waits, so an aborted conversion still ends the frame
      while (busy_in !== 1'b1 && k < 40) begin
        @(posedge sys_clk_in);
        k++;
      end
      while (busy_in === 1'b1 && k < 100) begin
        @(posedge sys_clk_in);
        k++;
      end
      w = {19'h0, sdo_in};
      // longer frame so the channel and gain bits fit after the code
      for (k = 1; k < 20; k++) begin
        sck_out <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        sck_out <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        w = {w[18:0], sdo_in};
      end
      word_out <= w;
      done_out <= 1'b1;
      @(posedge sys_clk_in);
      done_out <= 1'b0;
    end
  end
endmodule : host_link_model

//--- testbench/tb_adc_channel_sequencer_ctrl.sv
// Purpose: self-checking bench for the sequencer and conversion control block
// Assumes: host model owns start, serial clock and gate; bench owns other pins and bus
// Notes: expected frames are queued by the driver and compared when the host model ends a frame
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module tb_adc_channel_sequencer_ctrl;
  logic clk;
  logic rst_b = 1'b0;
  logic pwr_n = 1'b1;
  logic lp = 1'b1;
  logic [2:0] chan = 3'h0;
  logic [2:0] gain = 3'h0;
  logic byp = 1'b0;
  logic common_input = 1'b0;
  logic [13:0] core = 14'h0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic gate_req = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, sdo, sdo_oe, busy, rvalid, start_n, sck, gate, done, rd_ph = 1'b0;
  logic [19:0] word;
  logic hresp; // bus response, always okay
  logic [2:0] achan; // channel of the last conversion
  logic [3:0] again; // {bypass, code} of the last conversion
  logic [48:0] fq[$]; // {channel, gain, mask, expected} per frame
  logic [31:0] bq[$]; // expected read data
  logic [2:0] h_ch [0:127]; // channel pins latched per frame
  logic [3:0] h_gn [0:127]; // {bypass, gain code} per frame
  logic [13:0] last = 14'h0; // last expected result code
  logic [48:0] e;
  logic ext = 1'b1; // readout carries channel and gain bits
  int fn = 0, bcnt = 0, blen = 0, cyc = 0, n_tests = 0, n_mismatch = 0;

  adc_seq_ctrl dut_u (
    .sys_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .convert_start_n_in(start_n),
    .power_down_n_in(pwr_n), .low_power_select_in(lp), .sequencer_gate_in(gate),
    .chan_sel_bits_in(chan), .gain_sel_bits_in(gain), .gain_msb_bypass_pin_in(byp),
    .common_input_in(common_input), .sck_in(sck), .core_code_in(core), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .busy_out(busy), .result_valid_out(rvalid), .active_chan_out(achan),
    .active_gain_out(again));

  host_link_model host_u (
    .sys_clk_in(clk), .go_in(go), .gate_req_in(gate_req), .busy_in(busy), .sdo_in(sdo),
    .convert_start_n_out(start_n), .sck_out(sck), .gate_out(gate), .word_out(word),
    .done_out(done));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask : check

  task automatic test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask : test_done

  // single word transfer; the slave may stretch either phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
    end
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    begin
      bq.push_back(x);
      bus(1'b0, a, 32'h0);
    end
  endtask : rd

  // one frame; m: 0 ignore, 1 expect invalid only, 2 full check; ab aborts by power-down
  task automatic frame(input logic g, input int sc, input int m, input logic [2:0] cp,
                       input logic [3:0] gp, input logic ab);
    logic [13:0] c;
    logic [13:0] code;
    logic [2:0] ch;
    logic [3:0] gn;
    logic [3:0] ge;
    logic [20:0] msk;
    logic cb;
    int d;
    int k;
    begin
      c = 14'($urandom);
      cb = 1'($urandom);
      h_ch[fn] = cp;
      h_gn[fn] = gp;
      // low-power applies this rise's pins, normal the previous latch
      d = (lp === 1'b1) ? fn : fn - 1;
      ch = (sc >= 0) ? 3'(sc) : h_ch[d];
      gn = h_gn[d];
      code = cb ? {~c[13], c[12:0]} : c;
      last = code;
      msk = (m == 0) ? 21'h0 : (m == 1) ? 21'h100000 : 21'h1fffff;
      ge = {gn[3], gn[3] ? 3'h0 : gn[2:0]};
      fq.push_back({ch, ge, msk, m == 2, code, ext ? {ch, ge[2:0]} : 6'h0});
      chan <= cp;
      gain <= gp[2:0];
      byp <= gp[3];
      core <= c;
      common_input <= cb;
      gate_req <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      if (ab) begin
        repeat (4) @(posedge clk);
        check(32'(sdo_oe), 32'h0);
        while (busy !== 1'b1 && k < 40) begin
          @(posedge clk);
          k++;
        end
        check(32'(sdo_oe), 32'h1);
        pwr_n <= 1'b0;
        repeat (4) @(posedge clk);
        check(32'(busy), 32'h0);
        check(32'(sdo_oe), 32'h0);
      end
      while (done !== 1'b1 && k < 600) begin
        @(posedge clk);
        k++;
      end
      check(32'(done), 32'h1);
      @(posedge clk);
      fn++;
      if (ab) begin
        pwr_n <= 1'b1;
        repeat (8) @(posedge clk);
      end
    end
  endtask : frame

  // gate for 11 frames; then the exit sample and a return to pin selection
  task automatic seq_test;
    int n;
    begin
      for (n = 0; n < 14; n++) begin
        frame(n < 11, (n >= 1 && n <= 12) ? (n - 1) % 8 : -1,
              (n == 0) ? ((lp === 1'b1) ? 0 : 1) : (n == 1) ? 1 : 2,
              (n < 11) ? 3'($urandom) : 3'h5, 4'($urandom), 1'b0);
      end
      $display("sequencer test done");
    end
  endtask : seq_test

  task automatic pd_test(input logic low_power_select);
    begin
      lp <= low_power_select;
      frame(1'b0, -1, 0, 3'h2, 4'h1, 1'b0);
      frame(1'b0, -1, 0, 3'h2, 4'h1, 1'b1);
      frame(1'b0, -1, low_power_select ? 2 : 1, 3'h2, 4'h1, 1'b0);
      frame(1'b0, -1, 2, 3'h2, 4'h1, 1'b0);
      $display("power-down test done");
    end
  endtask : pd_test

  // frame monitor: oldest note against the finished frame
  always @(posedge clk) begin
    if (done === 1'b1 && fq.size() > 0) begin
      e = fq.pop_front();
      check(32'({rvalid, word} & e[41:21]), 32'(e[20:0] & e[41:21]));
      // selections still stand from the rise that preceded this conversion
      if (e[41:21] != 21'h0) begin
        check(32'({achan, again}), 32'(e[48:42]));
      end
    end
    if (rd_ph && hreadyout === 1'b1 && bq.size() > 0) begin
      check(hrdata, bq.pop_front());
      check(32'(hresp), 32'h0);
    end
    if (hreadyout === 1'b1) begin
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end

  // conversion length and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
    if (cyc > 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    int i;
    void'($urandom(64));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(32'h0, 32'h1);
    rd(32'h4, 32'h8);
    bus(1'b1, 32'h40, 32'hffff_ffff);
    rd(32'h40, 32'h0);
    bus(1'b1, 32'h0, 32'h0);
    ext = 1'b0;
    for (i = 0; i < 3; i++) frame(1'b0, -1, (i > 0) ? 2 : 0, 3'h1, 4'h2, 1'b0);
    check(32'(blen), 32'(`CONV_CYCLES));
    bus(1'b1, 32'h0, 32'h1);
    ext = 1'b1;
    $display("register test done");
    for (i = 0; i < 9; i++) frame(1'b0, -1, 2, 3'($urandom), (i < 8) ? {1'b0, 3'(i)} : 4'hf, 1'b0);
    rd(32'h8, {18'h0, last});
    bus(1'b1, 32'h8, 32'h0);
    rd(32'h8, {18'h0, last});
    $display("low-power channel test done");
    lp <= 1'b0;
    for (i = 0; i < 8; i++) frame(1'b0, -1, (i > 1) ? 2 : 0, 3'($urandom), 4'($urandom), 1'b0);
    $display("normal channel test done");
    seq_test();
    lp <= 1'b1;
    frame(1'b0, -1, 0, 3'h0, 4'h0, 1'b0);
    seq_test();
    pd_test(1'b1);
    pd_test(1'b0);
    test_done();
  end
endmodule : tb_adc_channel_sequencer_ctrl
